// [rtl/bsc_pkg.sv]
// Constants and types for the bit-test, call and clear execute block.
package bsc_pkg;
  // Word and field widths
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int LIT_W = 11;
  localparam int DATA_W = 8;
  // Field positions inside an instruction word
  localparam int FADDR_LSB = 0;
  localparam int BIT_LSB = 7;
  localparam int LIT_LSB = 0;
  // Opcode fields and the patterns that select each instruction
  localparam int SKIP_OP_LSB = 10;
  localparam logic [3:0] SKIP_OP = 4'h7;
  localparam int CALL_OP_LSB = 11;
  localparam logic [2:0] CALL_OP = 3'h4;
  localparam int CLR_OP_LSB = 7;
  localparam logic [6:0] CLR_OP = 7'h03;
  // Latch bits that feed the top of the program counter
  localparam int LATCH_W = 8;
  localparam int LATCH_HI_LSB = 3;
  // Value written by the clear, reset value of the stack-top and call-target outputs and the return-address step
  localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  // Execute states: the second two only fill a discarded fetch slot
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_SKIP_NOP,
    ST_CALL_SLOT
  } bsc_state_type;
endpackage : bsc_pkg

// [rtl/bsc_dec_if.sv]
// Decoded instruction fields shared between the decoder and the executor.
interface bsc_dec_if;
  import bsc_pkg::*;
  logic [INSTR_W-1:0] instr;
  logic is_bit_test_skip_if_set;
  logic is_call;
  logic is_clear_file_reg;
  logic [BIT_W-1:0] bit_sel;
  logic [FADDR_W-1:0] file_addr;
  logic [LIT_W-1:0] literal;
  modport dec (
    input instr,
    output is_bit_test_skip_if_set,
    output is_call,
    output is_clear_file_reg,
    output bit_sel,
    output file_addr,
    output literal
  );
  modport use_side (
    output instr,
    input is_bit_test_skip_if_set,
    input is_call,
    input is_clear_file_reg,
    input bit_sel,
    input file_addr,
    input literal
  );
endinterface : bsc_dec_if

// [rtl/bsc_decode.sv]
// Combinational field decoder for the three supported instruction words.
module bsc_decode (
  bsc_dec_if.dec dec
);
  import bsc_pkg::*;

  // Opcode matches, each on its own fixed field
  assign dec.is_bit_test_skip_if_set =
    (dec.instr[INSTR_W-1:SKIP_OP_LSB] == SKIP_OP);
  assign dec.is_call = (dec.instr[INSTR_W-1:CALL_OP_LSB] == CALL_OP);
  assign dec.is_clear_file_reg =
    (dec.instr[INSTR_W-1:CLR_OP_LSB] == CLR_OP);

  // Operand fields; unused ones are simply ignored downstream
  assign dec.bit_sel = dec.instr[BIT_LSB +: BIT_W];
  assign dec.file_addr = dec.instr[FADDR_LSB +: FADDR_W];
  assign dec.literal = dec.instr[LIT_LSB +: LIT_W];
endmodule : bsc_decode

// [rtl/bsc_exec.sv]
// Execute stage for bit-test-skip, subroutine call and register clear.
module bsc_exec (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [bsc_pkg::INSTR_W-1:0] instr,
  input wire logic [bsc_pkg::PC_W-1:0] pc,
  input wire logic [bsc_pkg::LATCH_W-1:0] pc_high_latch,
  output logic instr_known,
  output logic [bsc_pkg::FADDR_W-1:0] file_raddr,
  input wire logic [bsc_pkg::DATA_W-1:0] file_rdata,
  output logic file_we,
  output logic [bsc_pkg::FADDR_W-1:0] file_waddr,
  output logic [bsc_pkg::DATA_W-1:0] file_wdata,
  output logic zero_we,
  output logic zero_value,
  output logic stack_push,
  output logic [bsc_pkg::PC_W-1:0] stack_top,
  output logic pc_load,
  output logic [bsc_pkg::PC_W-1:0] pc_target,
  output logic fetch_discard,
  output logic nop_slot
);
  import bsc_pkg::*;

  // The call target must be exactly the latch pair above the literal
  if (PC_W != LIT_W + 2) begin : g_width_check
    $error("program counter width is not literal width plus two");
  end

  bsc_dec_if dec_bus ();
  bsc_state_type state_r;
  bsc_state_type state_nxt;

  logic take;
  logic bit_value;
  logic skip_taken;
  logic do_call;
  logic do_clear;
  logic [PC_W-1:0] return_addr;
  logic [PC_W-1:0] call_addr;

  logic file_we_r;
  logic [FADDR_W-1:0] file_waddr_r;
  logic zero_we_r;
  logic stack_push_r;
  logic [PC_W-1:0] stack_top_r;
  logic pc_load_r;
  logic [PC_W-1:0] pc_target_r;
  logic discard_r;

  // Field decode lives in its own module so the opcode map is in one place
  assign dec_bus.instr = instr;
  bsc_decode u_decode (
    .dec(dec_bus)
  );

  // A word is taken only in the plain execute state
  assign instr_ready = (state_r == ST_EXEC);
  assign take = instr_valid && instr_ready;
  assign instr_known = dec_bus.is_bit_test_skip_if_set
    || dec_bus.is_call || dec_bus.is_clear_file_reg;
  assign nop_slot = (state_r != ST_EXEC);

  // Register read address goes straight out; the file answers same cycle
  assign file_raddr = dec_bus.file_addr;
  assign bit_value = file_rdata[dec_bus.bit_sel];
  assign skip_taken =
    take && dec_bus.is_bit_test_skip_if_set && bit_value;
  assign do_call = take && dec_bus.is_call;
  assign do_clear = take && dec_bus.is_clear_file_reg;

  // Return address is the next sequential word, wrapped to the PC width
  assign return_addr = pc + PC_STEP;
  // Jump target: latch bits on top, literal below
  assign call_addr = {pc_high_latch[LATCH_HI_LSB +: PC_W-LIT_W],
    dec_bus.literal};

  // Sequencer: skip and call each burn the slot of the discarded fetch
  always_comb begin
    state_nxt = ST_EXEC;
    case (state_r)
      ST_EXEC: begin
        if (skip_taken) begin
          state_nxt = ST_SKIP_NOP;
        end else if (do_call) begin
          state_nxt = ST_CALL_SLOT;
        end else begin
          state_nxt = ST_EXEC;
        end
      end
      ST_SKIP_NOP: state_nxt = ST_EXEC;
      ST_CALL_SLOT: state_nxt = ST_EXEC;
      default: state_nxt = ST_EXEC;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Clear writes; zero flag is touched by nothing else in this block
  always_ff @(posedge clk) begin
    if (reset) begin
      file_we_r <= 1'b0;
      file_waddr_r <= '0;
      zero_we_r <= 1'b0;
    end else begin
      file_we_r <= do_clear;
      file_waddr_r <= dec_bus.file_addr;
      zero_we_r <= do_clear;
    end
  end

  // Call side effects: push and load come out together, one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      stack_push_r <= 1'b0;
      stack_top_r <= PC_RESET;
      pc_load_r <= 1'b0;
      pc_target_r <= PC_RESET;
    end else begin
      stack_push_r <= do_call;
      pc_load_r <= do_call;
      if (do_call) begin
        stack_top_r <= return_addr;
        pc_target_r <= call_addr;
      end
    end
  end

  // Prefetch discard, for both a taken skip and a call
  always_ff @(posedge clk) begin
    if (reset) begin
      discard_r <= 1'b0;
    end else begin
      discard_r <= skip_taken || do_call;
    end
  end

  assign file_we = file_we_r;
  assign file_waddr = file_waddr_r;
  assign file_wdata = CLEAR_VALUE;
  assign zero_we = zero_we_r;
  assign zero_value = 1'b1;
  assign stack_push = stack_push_r;
  assign stack_top = stack_top_r;
  assign pc_load = pc_load_r;
  assign pc_target = pc_target_r;
  assign fetch_discard = discard_r;

  // Checks on the outputs against the word that caused them
  chk_skip_discard: assert property (
    @(posedge clk) disable iff (reset)
    take && dec_bus.is_bit_test_skip_if_set && bit_value
    |=> fetch_discard && !pc_load)
    else $error("taken skip did not discard the fetch");

  chk_skip_two_cycles: assert property (
    @(posedge clk) disable iff (reset)
    skip_taken |=> nop_slot && !instr_ready ##1 instr_ready)
    else $error("taken skip did not last two cycles");

  // The filler slot must behave as a no-operation
  chk_slot_is_nop: assert property (
    @(posedge clk) disable iff (reset)
    nop_slot |=> !file_we && !zero_we && !stack_push && !pc_load
    && !fetch_discard)
    else $error("filler slot had a side effect");

  chk_noskip_single: assert property (
    @(posedge clk) disable iff (reset)
    take && dec_bus.is_bit_test_skip_if_set && !bit_value
    |=> instr_ready && !fetch_discard && !zero_we)
    else $error("untaken skip was not single cycle");

  chk_skip_no_effect: assert property (
    @(posedge clk) disable iff (reset)
    skip_taken |=> !file_we && !zero_we && !stack_push)
    else $error("taken skip touched a register or flag");

  chk_call_literal: assert property (
    @(posedge clk) disable iff (reset)
    do_call |=> pc_load
    && pc_target[LIT_W-1:0] == $past(instr[LIT_W-1:0]))
    else $error("call literal not in low PC bits");

  chk_call_push_value: assert property (
    @(posedge clk) disable iff (reset)
    do_call |=> stack_push && stack_top == PC_W'($past(pc) + 1))
    else $error("call pushed a wrong return address");

  chk_call_high_bits: assert property (
    @(posedge clk) disable iff (reset)
    do_call |=> pc_target[PC_W-1:LIT_W]
    == $past(pc_high_latch[4:3]))
    else $error("call high PC bits not from latch");

  chk_call_two_cycles: assert property (
    @(posedge clk) disable iff (reset)
    do_call |=> !instr_ready && !zero_we ##1 instr_ready)
    else $error("call did not take exactly two cycles");

  chk_clear_write: assert property (
    @(posedge clk) disable iff (reset)
    do_clear |=> file_we && file_wdata == 8'h00 && zero_we && zero_value
    && file_waddr == $past(instr[FADDR_W-1:0]) && instr_ready)
    else $error("clear did not write zero and set flag");

  chk_flag_cause: assert property (
    @(posedge clk) disable iff (reset)
    zero_we |-> $past(take) && $past(dec_bus.is_clear_file_reg))
    else $error("zero flag written without a clear");
endmodule : bsc_exec

// [verif/testbench.sv]
// Self-checking bench for the bit-test, call and clear execute block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bsc_pkg::*;
  // ex bits: known, file_we, zero_we, stack_push, pc_load, fetch_discard
  typedef struct {
    logic [13:0] ins;
    logic [12:0] pc;
    logic [7:0] lat;
    logic [7:0] rd;
    logic [5:0] ex;
    logic [12:0] tgt;
  } bsc_row_type;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [12:0] pc = 13'h0000;
  logic [7:0] pc_high_latch = 8'h00;
  logic [7:0] file_rdata = 8'h00;
  logic instr_ready, instr_known, file_we, zero_we, zero_value;
  logic stack_push, pc_load, fetch_discard, nop_slot;
  logic [6:0] file_raddr, file_waddr;
  logic [7:0] file_wdata;
  logic [12:0] stack_top, pc_target;
  int error_cnt = 0;
  int n_tests = 0;
  // Wrapping call, both latch extremes, opposite-sense test and junk words
  bsc_row_type rows [11] = '{
    '{14'h1FFF, 13'h0010, 8'h00, 8'h80, 6'h21, 13'h0000},
    '{14'h1C05, 13'h0011, 8'h00, 8'hFE, 6'h20, 13'h0000},
    '{14'h1D90, 13'h0012, 8'h00, 8'h08, 6'h21, 13'h0000},
    '{14'h27FF, 13'h1FFF, 8'h18, 8'h00, 6'h27, 13'h1FFF},
    '{14'h2000, 13'h0123, 8'hE7, 8'hFF, 6'h27, 13'h0000},
    '{14'h2555, 13'h0400, 8'h08, 8'h00, 6'h27, 13'h0D55},
    '{14'h01FF, 13'h0020, 8'h00, 8'h5A, 6'h38, 13'h0000},
    '{14'h0180, 13'h0021, 8'h00, 8'hFF, 6'h38, 13'h0000},
    '{14'h1800, 13'h0030, 8'h00, 8'h00, 6'h00, 13'h0000},
    '{14'h3FFF, 13'h0031, 8'hFF, 8'hFF, 6'h00, 13'h0000},
    '{14'h0000, 13'h0032, 8'h00, 8'h00, 6'h00, 13'h0000}
  };

  bsc_exec DUT (.clk(clk), .reset(reset), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .pc(pc),
    .pc_high_latch(pc_high_latch), .instr_known(instr_known),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .zero_we(zero_we),
    .zero_value(zero_value), .stack_push(stack_push),
    .stack_top(stack_top), .pc_load(pc_load), .pc_target(pc_target),
    .fetch_discard(fetch_discard), .nop_slot(nop_slot));

  // Half period of 25 ns gives 20 MHz
  always #25 clk = ~clk;

  task automatic chk_bit(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %b, seen %b", nm, e, s);
    end
  endtask : chk_bit

  task automatic chk_vec(input string nm, input logic [13:0] e,
                         input logic [13:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask : chk_vec

  task automatic give_verdict;
    $display("errors %0d, comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // One word offered, then its one-cycle-late effects checked
  task automatic run_row(input bsc_row_type r);
    @(negedge clk);
    instr = r.ins;
    pc = r.pc;
    pc_high_latch = r.lat;
    file_rdata = r.rd;
    instr_valid = 1'b1;
    #1;
    chk_bit("instr_ready", 1'b1, instr_ready);
    chk_bit("instr_known", r.ex[5], instr_known);
    chk_vec("file_raddr", {7'h00, r.ins[6:0]}, {7'h00, file_raddr});
    @(negedge clk);
    instr_valid = 1'b0;
    #1;
    chk_bit("file_we", r.ex[4], file_we);
    chk_bit("zero_we", r.ex[3], zero_we);
    chk_bit("stack_push", r.ex[2], stack_push);
    chk_bit("pc_load", r.ex[1], pc_load);
    chk_bit("fetch_discard", r.ex[0], fetch_discard);
    chk_bit("nop_slot", r.ex[0], nop_slot);
    chk_bit("instr_ready", ~r.ex[0], instr_ready);
    if (r.ex[2]) begin
      chk_vec("stack_top", {1'b0, r.pc + 13'h0001},
              {1'b0, stack_top});
      chk_vec("pc_target", {1'b0, r.tgt}, {1'b0, pc_target});
    end
    if (r.ex[4]) begin
      chk_vec("file_waddr", {7'h00, r.ins[6:0]}, {7'h00, file_waddr});
      chk_vec("file_wdata", 14'h0000, {6'h00, file_wdata});
      chk_bit("zero_value", 1'b1, zero_value);
    end
    if (r.ex[0]) begin
      @(negedge clk);
      #1;
      chk_bit("instr_ready", 1'b1, instr_ready);
      chk_bit("fetch_discard", 1'b0, fetch_discard);
    end
  endtask : run_row

  // Generous bound: the sequence needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    // Back-to-back clears must both be taken at once
    @(negedge clk);
    instr = 14'h0191;
    instr_valid = 1'b1;
    @(negedge clk);
    instr = 14'h01A2;
    #1;
    chk_bit("instr_ready", 1'b1, instr_ready);
    chk_vec("file_waddr", 14'h0011, {7'h00, file_waddr});
    @(negedge clk);
    instr_valid = 1'b0;
    #1;
    chk_bit("file_we", 1'b1, file_we);
    chk_vec("file_waddr", 14'h0022, {7'h00, file_waddr});
    // A word offered in the skipped slot is refused, then taken
    @(negedge clk);
    instr = 14'h1C80;
    file_rdata = 8'h02;
    instr_valid = 1'b1;
    @(negedge clk);
    instr = 14'h0185;
    #1;
    chk_bit("instr_ready", 1'b0, instr_ready);
    @(negedge clk);
    #1;
    chk_bit("file_we", 1'b0, file_we);
    chk_bit("instr_ready", 1'b1, instr_ready);
    @(negedge clk);
    instr_valid = 1'b0;
    #1;
    chk_vec("file_waddr", 14'h0005, {7'h00, file_waddr});
    // Reset in mid-run clears the held call results
    run_row(rows[5]);
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    #1;
    chk_vec("pc_target", 14'h0000, {1'b0, pc_target});
    chk_vec("stack_top", 14'h0000, {1'b0, stack_top});
    // Reset landing in a call's slot leaves no pulse and no stall behind
    @(negedge clk);
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    #1;
    chk_bit("stack_push", 1'b0, stack_push);
    chk_bit("instr_ready", 1'b1, instr_ready);
    chk_bit("nop_slot", 1'b0, nop_slot);
    chk_vec("pc_target", 14'h0000, {1'b0, pc_target});
    give_verdict();
  end
endmodule : testbench
